// *** fwdt_map.vh ***
`ifndef FWDT_MAP_VH
`define FWDT_MAP_VH
// Register offset of the control register
`define FWDT_CTRL_OFF      8'h2A
// Field positions
`define FWDT_ACT_BIT       7
`define FWDT_TOP_BIT       6
// Reset value of the control register
`define FWDT_CTRL_RST      8'h7F
// Prescaler period in oscillator cycles
`define FWDT_PRESC_CYC     16384
// Timebase correction constants (units of 64 cycles)
`define FWDT_TB0_K         59
`define FWDT_TB1_K         53
`define FWDT_TB2_K         35
`define FWDT_TB3_K         54
`define FWDT_K_BASE        128
`define FWDT_K_UNIT        64
// Reset pulse width in ns and clock period in ns
`define FWDT_RST_NS        30000
`define FWDT_CLK_NS        100
// Wake restart delays in processor clocks
`define FWDT_WAKE_SHORT    256
`define FWDT_WAKE_LONG     4096
`endif

// *** fwdt_prescaler.v ***
`timescale 1ns/100ps
`include "fwdt_map.vh"
module fwdt_prescaler #(
  parameter PRESC_CYC = `FWDT_PRESC_CYC
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       run_i,
  input  wire [1:0] timebase_select_i,
  output reg        tick_o
);
  localparam [14:0] TOP_CNT = PRESC_CYC - 1;
  reg  [14:0] cnt_q;
  wire [14:0] first;

  // First tick after reset uses the timebase phase offset
  function [14:0] first_cnt;
    input [1:0] tb;
    begin
      case (tb)
        2'h0:    first_cnt = (`FWDT_TB0_K + `FWDT_K_BASE) * `FWDT_K_UNIT;
        2'h1:    first_cnt = (`FWDT_TB1_K + `FWDT_K_BASE) * `FWDT_K_UNIT;
        2'h2:    first_cnt = (`FWDT_TB2_K + `FWDT_K_BASE) * `FWDT_K_UNIT;
        default: first_cnt = (`FWDT_TB3_K + `FWDT_K_BASE) * `FWDT_K_UNIT;
      endcase
    end
  endfunction

  assign first = first_cnt(timebase_select_i) - 15'h0001;
  // Reload until the synchronised timebase has settled
  reg  [1:0]  started_q;

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q     <= 15'h0000;
      started_q <= 2'h0;
      tick_o    <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (started_q != 2'h3)
      begin
        started_q <= started_q + 2'h1;
        cnt_q     <= first; // RULE_12
      end
      else if (run_i)
      begin
        if (cnt_q == 15'h0000)
        begin
          cnt_q  <= TOP_CNT; // RULE_01
          tick_o <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - 15'h0001;
        end
      end
    end
  end
endmodule // fwdt_prescaler

// *** fwdt_watchdog.v ***
`timescale 1ns/100ps
`include "fwdt_map.vh"
// Overview of operation
// RULE_01: Counter decrements every 16384 oscillator cycles
// RULE_02: Lower six bits set timeout steps
// RULE_03: Activated rollover 40h to 3Fh resets
// RULE_04: Counter runs even when not activated
// RULE_05: Software rewrites FFh to C0h periodically
// RULE_06: Deactivated after any reset; code clears act_q only on resetn_i, not after its own mcu_reset_n_o pulse
// RULE_07: Writes cannot deactivate once activated
// RULE_08: Activate with top bit clear resets
// RULE_09: Halt resets when activated, optional
// RULE_10: Hardware mode forces permanent activation
// RULE_11: Prescaler phase not reset on write
// RULE_12: Timebase selects first-decrement correction constant
// RULE_13: First decrement between minimum and maximum
// RULE_14: Control register resets to 7Fh
// RULE_15: After wake resume following delay
// RULE_16: Write loads counter next edge
module fwdt_watchdog #(
  parameter WAKE_LONG  = `FWDT_WAKE_LONG,
  parameter WAKE_SHORT = `FWDT_WAKE_SHORT,
  parameter PRESC_CYC  = `FWDT_PRESC_CYC
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire [1:0] timebase_select_i,
  input  wire       hw_watchdog_i,
  input  wire       halt_reset_option_i,
  input  wire       halt_exec_i,
  input  wire       ext_wake_i,
  input  wire       long_wake_i,
  output reg        mcu_reset_n_o
);
  localparam RST_CYC  = `FWDT_RST_NS / `FWDT_CLK_NS;
  localparam ST_RUN   = 2'h0;
  localparam ST_HALT  = 2'h1;
  localparam ST_WAKE  = 2'h2;
  localparam ST_RESET = 2'h3;

  reg        act_q;
  reg  [6:0] timeout_count_q;
  reg  [1:0] state_q;
  reg  [12:0] wait_q;
  reg  [9:0] pulse_q;
  reg  [1:0] hw_sync_q;
  reg  [1:0] tb_meta_q;
  reg  [1:0] tb_sync_q;
  reg  [1:0] hro_sync_q;
  reg  [1:0] halt_sync_q;
  reg  [1:0] wake_sync_q;
  reg  [1:0] long_sync_q;
  wire       tick;
  wire       active;
  wire       ctrl_wr;
  wire       run;
  wire       roll;
  wire       sw_rst;
  wire       halt_rst;

  // Two-stage synchronisers for pin inputs
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hw_sync_q   <= 2'h0;
      tb_meta_q   <= 2'h0;
      tb_sync_q   <= 2'h0;
      hro_sync_q  <= 2'h0;
      halt_sync_q <= 2'h0;
      wake_sync_q <= 2'h0;
      long_sync_q <= 2'h0;
    end
    else
    begin
      hw_sync_q   <= {hw_sync_q[0], hw_watchdog_i};
      tb_meta_q   <= timebase_select_i;
      tb_sync_q   <= tb_meta_q;
      hro_sync_q  <= {hro_sync_q[0], halt_reset_option_i};
      halt_sync_q <= {halt_sync_q[0], halt_exec_i};
      wake_sync_q <= {wake_sync_q[0], ext_wake_i};
      long_sync_q <= {long_sync_q[0], long_wake_i};
    end
  end

  assign ctrl_wr  = wr_i && (addr_i == `FWDT_CTRL_OFF);
  assign active   = act_q || hw_sync_q[1]; // RULE_10
  assign run      = (state_q == ST_RUN); // RULE_04
  assign roll     = tick && run && (timeout_count_q == 7'h40); // RULE_03
  assign sw_rst   = ctrl_wr && !wdata_i[`FWDT_TOP_BIT]
                    && (wdata_i[`FWDT_ACT_BIT] || active); // RULE_08
  assign halt_rst = halt_sync_q[1] && hro_sync_q[1] && active; // RULE_09

  fwdt_prescaler #(
    .PRESC_CYC (PRESC_CYC)
  ) u_presc (
    .clk_i             (clk_i),
    .resetn_i          (resetn_i),
    .run_i             (run), // RULE_11
    .timebase_select_i (tb_sync_q),
    .tick_o            (tick) // RULE_13
  );

  // Control register and counter
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      act_q           <= 1'b0; // RULE_06
      timeout_count_q <= 7'h7F; // RULE_14
    end
    else if (ctrl_wr)
    begin
      act_q           <= act_q | wdata_i[`FWDT_ACT_BIT]; // RULE_07
      timeout_count_q <= wdata_i[6:0]; // RULE_16
    end
    else if (tick && run)
    begin
      timeout_count_q <= timeout_count_q - 7'h01; // RULE_01
    end
  end
  // Lower six bits give 64 programmable steps before top bit falls // RULE_02

  // Halt, wake and reset pulse sequencing
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q       <= ST_RUN;
      wait_q        <= 13'h0000;
      pulse_q       <= 10'h000;
      mcu_reset_n_o <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if ((roll && active) || (sw_rst && !act_q) || (sw_rst && act_q) || halt_rst)
          begin
            state_q       <= ST_RESET;
            pulse_q       <= RST_CYC[9:0] - 10'h001;
            mcu_reset_n_o <= 1'b0; // RULE_03
          end
          else if (halt_sync_q[1])
          begin
            state_q <= ST_HALT;
          end
        end
        ST_HALT:
        begin
          if (wake_sync_q[1])
          begin
            state_q <= ST_WAKE;
            wait_q  <= long_sync_q[1] ? WAKE_LONG[12:0] - 13'h0001
                                      : WAKE_SHORT[12:0] - 13'h0001; // RULE_15
          end
        end
        ST_WAKE:
        begin
          if (wait_q == 13'h0000)
          begin
            state_q <= ST_RUN;
          end
          else
          begin
            wait_q <= wait_q - 13'h0001;
          end
        end
        default:
        begin
          if (pulse_q == 10'h000)
          begin
            state_q       <= ST_RUN;
            mcu_reset_n_o <= 1'b1;
          end
          else
          begin
            pulse_q <= pulse_q - 10'h001;
          end
        end
      endcase
    end
  end

  // Register read port, data one cycle after strobe
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i && (addr_i == `FWDT_CTRL_OFF))
    begin
      rdata_o <= {act_q, timeout_count_q};
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end
endmodule // fwdt_watchdog

// *** fwdt_watchdog_monitor.sv ***
`timescale 1ns/100ps
module fwdt_monitor (
  input wire       clk_i,
  input wire       resetn_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       hw_watchdog_i,
  input wire       halt_reset_option_i,
  input wire       halt_exec_i,
  input wire       mcu_reset_n_o
);
  logic       act_q;
  logic       hw_q;
  logic [8:0] low_q;
  wire        wr_c  = wr_i && addr_i == 8'h2A;
  wire        act_c = act_q || (wr_c && wdata_i[7]);
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      act_q <= 1'b0;
      hw_q  <= 1'b0;
      low_q <= 9'h000;
    end
    else
    begin
      act_q <= act_c;
      hw_q  <= hw_q || hw_watchdog_i;
      low_q <= mcu_reset_n_o ? 9'h000 : low_q + 9'h001;
    end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not zero");
  chk_rd_unmap: assert property (rd_i && addr_i != 8'h2A |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rst_vals: assert property ($rose(resetn_i) |-> mcu_reset_n_o)
    else $error("reset output low after reset");
  chk_pulse_len: assert property ($rose(mcu_reset_n_o) |-> low_q == 9'h12C)
    else $error("reset pulse width wrong");
  chk_sw_reset: assert property (wr_c && wdata_i[7:6] == 2'h2 && mcu_reset_n_o
    |=> !mcu_reset_n_o)
    else $error("software reset missing");
  chk_quiet: assert property (!act_c && !hw_q && !hw_watchdog_i && mcu_reset_n_o
    |=> mcu_reset_n_o)
    else $error("reset while inactive");
  chk_act_stick: assert property (rd_i && addr_i == 8'h2A && act_q |=> rdata_o[7])
    else $error("activate bit lost");
  chk_halt_rst: assert property (halt_exec_i && halt_reset_option_i && act_q
    && mcu_reset_n_o |-> ##[1:4] !mcu_reset_n_o)
    else $error("halt reset missing");
  cover property ($fell(mcu_reset_n_o));
  cover property (rd_i && addr_i == 8'h2A && act_q);
  cover property (halt_exec_i && act_q);
endmodule // fwdt_monitor
bind fwdt_watchdog fwdt_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .hw_watchdog_i(hw_watchdog_i), .halt_reset_option_i(halt_reset_option_i),
  .halt_exec_i(halt_exec_i), .mcu_reset_n_o(mcu_reset_n_o));

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic       clk_i;
  logic       resetn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       hw_i;
  logic       hopt_i;
  logic       halt_i;
  logic [7:0] d;
  logic [7:0] v;
  logic [7:0] h;
  logic [1:0] tb_sel;
  logic       wake_i;
  logic       lwake_i;
  wire  [7:0] rdata_o;
  wire        mrst_n;
  integer     n_errors;
  integer     total_checks;
  integer     seed;
  fwdt_watchdog #(.WAKE_LONG(8), .WAKE_SHORT(4), .PRESC_CYC(256)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timebase_select_i(tb_sel),
    .hw_watchdog_i(hw_i), .halt_reset_option_i(hopt_i), .halt_exec_i(halt_i),
    .ext_wake_i(wake_i), .long_wake_i(lwake_i), .mcu_reset_n_o(mrst_n));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= x;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rst;
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
  endtask
  task automatic pulse(input integer lim);
    integer n;
    n = 0;
    #1;
    while (mrst_n !== 1'b0 && n < lim)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    halt_i <= 1'b0;
    chk("rst_seen", 16'h0001, {15'h0000, n < lim});
    n = 0;
    while (mrst_n === 1'b0 && n < 400)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("rst_len", 16'h012C, n[15:0]);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
  initial
  begin
    seed = 9263;
    n_errors = 0;
    total_checks = 0;
    {addr_i, wdata_i, wr_i, rd_i, hw_i, hopt_i, halt_i, wake_i, lwake_i} = '0;
    tb_sel = 2'h2;
    resetn_i = 1'b0;
    rst;
    rd(8'h2A);
    chk("ctrl_rst", 16'h007F, {8'h00, d});
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'h00 : 8'h7F & $random(seed);
      wr(8'h2A, v);
      rd(8'h2A);
      chk("ctrl_wr", {8'h00, v}, {8'h00, d});
      rd(8'h80 | $random(seed));
      chk("unmapped", 16'h0000, {8'h00, d});
    end
    $display("test regs done");
    wr(8'h2A, 8'h7F);
    repeat (11000) @(posedge clk_i);
    rd(8'h2A);
    chk("free_run", 16'h0001, {15'h0000, d < 8'h7F && d > 8'h78});
    wr(8'h2A, 8'hC1);
    wr(8'h2A, 8'h41);
    rd(8'h2A);
    chk("act_stick", 16'h0001, {15'h0000, d[7]});
    pulse(700);
    $display("test rollover done");
    rst;
    rd(8'h2A);
    chk("act_clear", 16'h007F, {8'h00, d});
    wr(8'h2A, 8'h80);
    pulse(2);
    rst;
    wr(8'h2A, 8'hFF);
    hopt_i <= 1'b1;
    halt_i <= 1'b1;
    pulse(10);
    $display("test halt done");
    rst;
    hw_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(8'h2A, 8'h00);
    pulse(2);
    $display("test hardware mode done");
    hw_i   <= 1'b0;
    hopt_i <= 1'b0;
    rst;
    wr(8'h2A, 8'hFF);
    repeat (10500) @(posedge clk_i);
    halt_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    halt_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h2A);
    h = d;
    repeat (600) @(posedge clk_i);
    rd(8'h2A);
    chk("halt_frozen", {8'h00, h}, {8'h00, d});
    lwake_i <= $random(seed) & 1;
    wake_i  <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake_i  <= 1'b0;
    repeat (600) @(posedge clk_i);
    rd(8'h2A);
    chk("wake_resume", 16'h0001, {15'h0000, d < h});
    chk("wake_no_rst", 16'h0001, {15'h0000, mrst_n});
    $display("test halt wake done");
    end_sim;
  end
endmodule // tb_top
